// File: rtl/hdtc_top.v
// Hypervisor debug trap control register with its trap decode.
`timescale 1ns/100ps
`include "hdtc_map.vh"
module hdtc_top #(
    parameter N_CNT = 31
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             cp_valid,
    input  wire             cp_write,
    input  wire [3:0]       cp_coproc,
    input  wire [2:0]       cp_opc1,
    input  wire [2:0]       cp_opc2,
    input  wire [3:0]       cp_crn,
    input  wire [3:0]       cp_crm,
    input  wire [31:0]      cp_wdata,
    input  wire [1:0]       cur_level,
    input  wire             in_hyp_mode,
    input  wire             debug_state,
    input  wire [2:0]       dbg_class,
    input  wire             mon_access,
    input  wire             mon_ctrl_access,
    input  wire             mon_mmio_access,
    input  wire             trap_general_exceptions,
    input  wire             group1_hyp_trap,
    input  wire             user_debug_comms_disable,
    input  wire             user_monitor_access_enable,
    input  wire [4:0]       implemented_counter_count,
    input  wire             cycle_count_disable_flag,
    input  wire             global_monitor_enable,
    input  wire             ext_override,
    input  wire [N_CNT-1:0] counter_enable_set,
    input  wire [N_CNT-1:0] count_prohibited,
    input  wire             cyc_enable_set,
    input  wire             cyc_prohibited,
    output reg  [31:0]      cp_rdata,
    output wire             cp_undef,
    output wire             reg_trap,
    output wire             dbg_trap,
    output wire             mon_trap,
    output wire             route_debug_exc,
    output wire [N_CNT-1:0] count_allow,
    output wire [N_CNT-1:0] guest_access,
    output wire [N_CNT-1:0] ext_access,
    output wire             cyc_allow
);
    reg  [21:0] ctrl_q;
    reg         gcc_load_q;
    reg  [4:0]  gcc_q;
    wire        hit;
    wire        lvl01;
    wire        route_eff;
    wire        rom_eff;
    wire        pd_eff;
    wire        dbg_eff;
    wire        gcc_bad;
    wire [4:0]  gcc_eff;
    wire        wr_ok;

    // Mask and reset image stay 32-bit words; only bits 21:0 are stored.
    localparam [31:0] WR_MASK  = `HDTC_WR_MASK;
    localparam [31:0] RST_CTRL = `HDTC_RESET_CTRL;

    assign hit = cp_valid & (cp_coproc == `HDTC_COPROC) &
                 (cp_opc1 == `HDTC_OPC1) & (cp_opc2 == `HDTC_OPC2) &
                 (cp_crn == `HDTC_CRN) & (cp_crm == `HDTC_CRM);
    assign lvl01 = (cur_level == `HDTC_EL0) | (cur_level == `HDTC_EL1);

    // group-1 trap on level 1 access
    assign reg_trap = hit & (cur_level == `HDTC_EL1) & group1_hyp_trap;
    // Level 0 can never reach the register; level 1 without trap is undef.
    assign cp_undef = hit & (cur_level != `HDTC_EL2) & ~reg_trap;
    assign wr_ok = hit & cp_write & (cur_level == `HDTC_EL2);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= RST_CTRL[21:0];
        end else if (wr_ok) begin
            ctrl_q <= cp_wdata[21:0] & WR_MASK[21:0];
        end
    end

    // The count field cannot take a port value under async reset, so a
    // flag set by reset makes the first clock after release load it.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gcc_load_q <= 1'b1;
            gcc_q      <= 5'h00;
        end else if (gcc_load_q) begin
            gcc_load_q <= 1'b0;
            gcc_q      <= implemented_counter_count;
        end else if (wr_ok) begin
            gcc_q <= cp_wdata[`HDTC_GCC_MSB:`HDTC_GCC_LSB];
        end
    end

    // Read data is registered; bad count values read as zero here.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_rdata <= 32'h00000000;
        end else if (hit & ~cp_write & (cur_level == `HDTC_EL2)) begin
            cp_rdata <= {10'h000, ctrl_q[21:5],
                         gcc_bad ? 5'h00 : gcc_q};
        end
    end

    assign gcc_bad = (gcc_q == 5'h00) | (gcc_q > implemented_counter_count);
    assign gcc_eff = gcc_bad ? 5'h00 : gcc_q;

    assign route_eff = ctrl_q[`HDTC_BIT_ROUTE] | trap_general_exceptions;
    assign rom_eff = ctrl_q[`HDTC_BIT_ROM_TRAP] | route_eff;
    assign pd_eff  = ctrl_q[`HDTC_BIT_PD_TRAP] | route_eff;
    assign dbg_eff = ctrl_q[`HDTC_BIT_DBG_TRAP] | route_eff;
    assign route_debug_exc = route_eff & lvl01;

    // Trap decode for debug register accesses, by class of register.
    function dbg_trap_f;
        input [2:0] cls;
        input [1:0] lvl;
        input       rom;
        input       pd;
        input       dbg;
        input       udcc;
        input       dstate;
        begin
            case (cls)
                `HDTC_DCLS_ROM:   dbg_trap_f = rom & ~udcc &
                                  (lvl == `HDTC_EL0 || lvl == `HDTC_EL1);
                `HDTC_DCLS_PD:    dbg_trap_f = pd & (lvl == `HDTC_EL1);
                `HDTC_DCLS_DTR:   dbg_trap_f = dbg & ~udcc & ~dstate &
                                  (lvl == `HDTC_EL0 || lvl == `HDTC_EL1);
                `HDTC_DCLS_OTHER: dbg_trap_f = dbg & ~udcc &
                                  (lvl == `HDTC_EL0 || lvl == `HDTC_EL1);
                default:          dbg_trap_f = 1'b0;
            endcase
        end
    endfunction

    assign dbg_trap = dbg_trap_f(dbg_class, cur_level, rom_eff, pd_eff,
                                 dbg_eff, user_debug_comms_disable,
                                 debug_state);

    assign mon_trap = lvl01 & ~mon_mmio_access &
                      ((mon_access & ctrl_q[`HDTC_BIT_MON_TRAP]) |
                       (mon_ctrl_access & ctrl_q[`HDTC_BIT_MCR_TRAP] &
                        ~((cur_level == `HDTC_EL0) &
                          ~user_monitor_access_enable)));

    hdtc_counter_gate #(
        .N_CNT (N_CNT)
    ) u_gate (
        .gcc_eff        (gcc_eff),
        .impl_count     (implemented_counter_count),
        .global_en      (global_monitor_enable),
        .hyp_cnt_en     (ctrl_q[`HDTC_BIT_HYP_CNT_EN]),
        .hyp_prohibit   (ctrl_q[`HDTC_BIT_HYP_PROHIBIT]),
        .in_hyp_mode    (in_hyp_mode),
        .ext_block      (ctrl_q[`HDTC_BIT_EXT_BLOCK]),
        .ext_override   (ext_override),
        .cycle_dis_flag (cycle_count_disable_flag),
        .cnt_enable_set (counter_enable_set),
        .prohibited     (count_prohibited),
        .cyc_enable_set (cyc_enable_set),
        .cyc_prohibited (cyc_prohibited),
        .count_allow    (count_allow),
        .guest_access   (guest_access),
        .ext_access     (ext_access),
        .cyc_allow      (cyc_allow)
    );
endmodule

// File: pkg/hdtc_map.vh
// Constants for the hypervisor debug trap control register and its decode.
//
// Function
// - Bit 21 blocks external debugger access to reserved counters unless overridden.
// - Bit 17 stops guest counters counting while in hypervisor mode.
// - Cycle counter follows bit 17 only when cycle-count-disable flag is set.
// - Bit 11 traps level 0/1 ROM and self address accesses unless user debug comms are disabled.
// - Bit 10 traps level 1 powerdown and OS lock register accesses.
// - Bit 9 traps remaining level 0/1 debug register accesses unless user debug comms are disabled.
// - In Debug state, transfer receive/transmit register traps are ignored.
// - General-exception trap or routing bit forces bits 11, 10, 9 effective.
// - Bit 8 routes level 0/1 debug exceptions and debug accesses to level 2.
// - General-exception trap makes routing bit effective; reads return stored value.
// - Bit 7 enables hypervisor counters through counter enable set bits.
// - Enabled counters do not count while counting is prohibited.
// - Bit 6 traps level 0/1 accesses to all monitor registers.
// - Memory-mapped external debug monitor accesses are never trapped.
// - Bit 5 traps level 0/1 monitor control accesses unless already trapped.
// - Counters below guest count are guest-accessible and globally enabled.
// - Counters from guest count to implemented count are level 2 only.
// - Guest count zero or too large: reads unknown, all reserved for level 2.
// - Reset loads guest counter count with implemented counter count.
// - Warm reset clears trap bits; hyp counter enable reset value is unknown.
// - Access via coproc 15, opc1 100, opc2 001, CRn/CRm 0001, level 2 only.
// - Group-1 hypervisor trap makes level 1 accesses to this register trap.
`ifndef HDTC_MAP_VH
`define HDTC_MAP_VH
`define HDTC_BIT_EXT_BLOCK    21
`define HDTC_BIT_HYP_PROHIBIT 17
`define HDTC_BIT_ROM_TRAP     11
`define HDTC_BIT_PD_TRAP      10
`define HDTC_BIT_DBG_TRAP     9
`define HDTC_BIT_ROUTE        8
`define HDTC_BIT_HYP_CNT_EN   7
`define HDTC_BIT_MON_TRAP     6
`define HDTC_BIT_MCR_TRAP     5
`define HDTC_GCC_MSB          4
`define HDTC_GCC_LSB          0
`define HDTC_WR_MASK          32'h00220fff
`define HDTC_RESET_CTRL       32'h00000000
`define HDTC_COPROC           4'hf
`define HDTC_OPC1             3'h4
`define HDTC_OPC2             3'h1
`define HDTC_CRN              4'h1
`define HDTC_CRM              4'h1
`define HDTC_EL0              2'h0
`define HDTC_EL1              2'h1
`define HDTC_EL2              2'h2
// Debug register classes of an access in coproc 14 space.
`define HDTC_DCLS_NONE        3'h0
`define HDTC_DCLS_ROM         3'h1
`define HDTC_DCLS_PD          3'h2
`define HDTC_DCLS_DTR         3'h3
`define HDTC_DCLS_OTHER       3'h4
`endif

// File: rtl/hdtc_counter_gate.v
// Per-counter enable and access gating for the event counters.
`timescale 1ns/100ps
`include "hdtc_map.vh"
module hdtc_counter_gate #(
    parameter N_CNT = 31
) (
    input  wire [4:0]       gcc_eff,
    input  wire [4:0]       impl_count,
    input  wire             global_en,
    input  wire             hyp_cnt_en,
    input  wire             hyp_prohibit,
    input  wire             in_hyp_mode,
    input  wire             ext_block,
    input  wire             ext_override,
    input  wire             cycle_dis_flag,
    input  wire [N_CNT-1:0] cnt_enable_set,
    input  wire [N_CNT-1:0] prohibited,
    input  wire             cyc_enable_set,
    input  wire             cyc_prohibited,
    output wire [N_CNT-1:0] count_allow,
    output wire [N_CNT-1:0] guest_access,
    output wire [N_CNT-1:0] ext_access,
    output wire             cyc_allow
);
    genvar i;
    generate
        for (i = 0; i < N_CNT; i = i + 1) begin : g_cnt
            wire in_impl;
            wire guest;
            wire en;
            assign in_impl = (i < impl_count);
            assign guest = (i < gcc_eff);
            assign en = cnt_enable_set[i] &
                        (guest ? global_en : hyp_cnt_en);
            assign count_allow[i] = in_impl & en & ~prohibited[i] &
                                    ~(guest & hyp_prohibit & in_hyp_mode);
            assign guest_access[i] = in_impl & guest;
            assign ext_access[i] = in_impl &
                                   (guest | ~ext_block | ext_override);
        end
    endgenerate

    // cycle counter bit 17 hyp-mode prohibit only with flag set
    assign cyc_allow = cyc_enable_set & global_en & ~cyc_prohibited &
                       ~(cycle_dis_flag & hyp_prohibit & in_hyp_mode);
endmodule

// File: bench/hdtc_asserts.sv
// Port-level checks for the hypervisor debug trap control block.
`timescale 1ns/100ps
`include "hdtc_map.vh"
module hdtc_asserts (
    input wire        clk,
    input wire        rst_n,
    input wire        cp_valid,
    input wire        cp_write,
    input wire [3:0]  cp_coproc,
    input wire [2:0]  cp_opc1,
    input wire [2:0]  cp_opc2,
    input wire [3:0]  cp_crn,
    input wire [3:0]  cp_crm,
    input wire [1:0]  cur_level,
    input wire        debug_state,
    input wire [2:0]  dbg_class,
    input wire        mon_mmio_access,
    input wire        trap_general_exceptions,
    input wire        group1_hyp_trap,
    input wire        user_debug_comms_disable,
    input wire [31:0] cp_rdata,
    input wire        cp_undef,
    input wire        reg_trap,
    input wire        dbg_trap,
    input wire        mon_trap,
    input wire        route_debug_exc
);
    // An access to this register is recognised only on its full encoding.
    wire hit = cp_valid && cp_coproc == `HDTC_COPROC
        && cp_opc1 == `HDTC_OPC1 && cp_opc2 == `HDTC_OPC2
        && cp_crn == `HDTC_CRN && cp_crm == `HDTC_CRM;
    wire low = cur_level != `HDTC_EL2;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_l1_group_trap: assert property (hit && cur_level == `HDTC_EL1
        && group1_hyp_trap |-> reg_trap) else $error("level 1 not trapped");
    a_l0_undef: assert property (hit && cur_level == `HDTC_EL0
        |-> cp_undef && !reg_trap) else $error("level 0 access not undef");
    a_read_resvd: assert property (hit && !cp_write && !low
        |=> (cp_rdata & ~`HDTC_WR_MASK) == 32'h0) else $error("reserved set");
    a_rom_forced: assert property (low && trap_general_exceptions
        && dbg_class == `HDTC_DCLS_ROM && !user_debug_comms_disable
        |-> dbg_trap) else $error("rom access not forced to trap");
    a_pd_forced: assert property (cur_level == `HDTC_EL1
        && dbg_class == `HDTC_DCLS_PD && trap_general_exceptions
        |-> dbg_trap) else $error("powerdown access not trapped");
    a_dtr_ignored: assert property (debug_state
        && dbg_class == `HDTC_DCLS_DTR |-> !dbg_trap)
        else $error("transfer trap in debug state");
    a_mmio_free: assert property (mon_mmio_access |-> !mon_trap)
        else $error("memory-mapped monitor access trapped");
    a_route_forced: assert property (trap_general_exceptions && low
        |-> route_debug_exc) else $error("debug exception not routed");
    a_l2_untrapped: assert property (!low
        |-> !dbg_trap && !mon_trap) else $error("level 2 access trapped");
    a_udcc_rom_free: assert property (user_debug_comms_disable
        && dbg_class == `HDTC_DCLS_ROM |-> !dbg_trap)
        else $error("rom access trapped despite comms disable");
endmodule

bind hdtc_top hdtc_asserts u_chk (.clk(clk), .rst_n(rst_n),
    .cp_valid(cp_valid), .cp_write(cp_write), .cp_coproc(cp_coproc),
    .cp_opc1(cp_opc1), .cp_opc2(cp_opc2), .cp_crn(cp_crn), .cp_crm(cp_crm),
    .cur_level(cur_level), .debug_state(debug_state), .dbg_class(dbg_class),
    .mon_mmio_access(mon_mmio_access),
    .trap_general_exceptions(trap_general_exceptions),
    .group1_hyp_trap(group1_hyp_trap),
    .user_debug_comms_disable(user_debug_comms_disable),
    .cp_rdata(cp_rdata), .cp_undef(cp_undef), .reg_trap(reg_trap),
    .dbg_trap(dbg_trap), .mon_trap(mon_trap),
    .route_debug_exc(route_debug_exc));

// File: bench/tb.sv
// Self-checking bench for the hypervisor debug trap control block.
`timescale 1ns/100ps
`include "hdtc_map.vh"
module tb;
    reg         clk, rst_n, vld, wr, ds, tge, g1, mma, mmio;
    reg  [17:0] enc;
    reg  [31:0] wd, d, m;
    reg  [1:0]  lvl, zr, tr;
    reg  [2:0]  cls, e;
    reg  [4:0]  impl;
    reg  [68:0] msc;
    reg  [30:0] xa, xg, xe;
    reg         xc, gs;
    integer     miscompares, checks, i, c, cyc, k, ge;
    wire [31:0] cp_rdata;
    wire [30:0] ca, ga, ea;
    wire        cya;
    wire        cp_undef, reg_trap, dbg_trap, mon_trap, route_debug_exc;
    // Coproc 1111, opc1 100, opc2 001, CRn 0001, CRm 0001.
    localparam [17:0] GOOD = 18'h3e111;

    hdtc_top dut (.clk(clk), .rst_n(rst_n), .cp_valid(vld), .cp_write(wr),
        .cp_coproc(enc[17:14]), .cp_opc1(enc[13:11]), .cp_opc2(enc[10:8]),
        .cp_crn(enc[7:4]), .cp_crm(enc[3:0]), .cp_wdata(wd),
        .cur_level(lvl), .in_hyp_mode(msc[0]), .debug_state(ds),
        .dbg_class(cls), .mon_access(mma), .mon_ctrl_access(zr[0]),
        .mon_mmio_access(mmio), .trap_general_exceptions(tge),
        .group1_hyp_trap(g1), .user_debug_comms_disable(zr[1]),
        .user_monitor_access_enable(msc[1]),
        .implemented_counter_count(impl),
        .cycle_count_disable_flag(msc[2]), .global_monitor_enable(msc[3]),
        .ext_override(msc[4]), .counter_enable_set(msc[37:7]),
        .count_prohibited(msc[68:38]), .cyc_enable_set(msc[5]),
        .cyc_prohibited(msc[6]), .cp_rdata(cp_rdata), .cp_undef(cp_undef),
        .reg_trap(reg_trap), .dbg_trap(dbg_trap), .mon_trap(mon_trap),
        .route_debug_exc(route_debug_exc), .count_allow(ca),
        .guest_access(ga), .ext_access(ea), .cyc_allow(cya));

    // Reads of an invalid guest count come back as zero by design choice.
    function [31:0] rdexp(input [31:0] v);
        begin
            rdexp = v;
            if (v[4:0] == 5'h00 || v[4:0] > impl)
                rdexp[4:0] = 5'h00;
        end
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    // One access held for one edge; refusal flags are sampled while it stands.
    task acc(input [1:0] l, input g, input w, input [31:0] dd);
        begin
            @(posedge clk);
            vld <= 1'b1;
            wr <= w;
            wd <= dd;
            lvl <= l;
            g1 <= g;
            #1;
            tr = {reg_trap, cp_undef};
            @(posedge clk);
            vld <= 1'b0;
            #1;
        end
    endtask

    task end_sim;
        begin
            if (miscompares == 0 && checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang is cut short well beyond the length of the sequence.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end

    initial begin
        {rst_n, vld, wr, ds, tge, g1, mma, mmio, wd, lvl, zr, cls, msc} = 0;
        enc = GOOD;
        impl = 5'h08;
        miscompares = 0;
        checks = 0;
        cyc = 0;
        d = $urandom(75);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        m = {27'h0, impl};
        acc(2'h2, 1'b0, 1'b0, 32'h0);
        chk(cp_rdata, rdexp(m));
        for (i = 0; i < 12; i = i + 1) begin
            d = $urandom;
            if (i == 0)
                d[4:0] = 5'h00;
            if (i == 1)
                d[4:0] = impl + 5'h01;
            acc(2'h2, 1'b0, 1'b1, d);
            m = d & `HDTC_WR_MASK;
            acc(2'h2, 1'b0, 1'b0, 32'h0);
            chk(cp_rdata, rdexp(m));
            for (c = 0; c < 5; c = c + 1) begin
                @(posedge clk);
                cls <= c[2:0];
                lvl <= $urandom % 3;
                {tge, ds, mma, mmio, zr} <= $urandom;
                msc <= {$urandom, $urandom, $urandom};
                #1;
                // Effective trap bits apply only below level 2.
                e = (m[11:9] | {3{tge | m[8]}}) & {3{lvl != 2'h2}};
                e = {(c == 1) ? e[2] & !zr[1] : (c == 2) ? e[1] & lvl[0]
                     : (c > 2) & e[0] & !zr[1] & !(c == 3 && ds),
                     (lvl != 2'h2) & !mmio & (m[6] & mma | m[5] & zr[0]
                     & !(lvl == 2'h0 && !msc[1])),
                     (m[8] | tge) & (lvl != 2'h2)};
                chk({dbg_trap, mon_trap, route_debug_exc}, e);
                // Counter split from the stored guest count, bad means zero.
                ge = (m[4:0] == 5'h00 || m[4:0] > impl) ? 0 : m[4:0];
                for (k = 0; k < 31; k = k + 1) begin
                    gs = k < ge;
                    xa[k] = k < impl && msc[7 + k] && (gs ? msc[3] : m[7])
                            && !msc[38 + k] && !(gs && m[17] && msc[0]);
                    xg[k] = k < impl && gs;
                    xe[k] = k < impl && (gs || !m[21] || msc[4]);
                end
                xc = msc[5] && msc[3] && !msc[6]
                     && !(msc[2] && m[17] && msc[0]);
                chk(ca, xa);
                chk(ga, xg);
                chk(ea, xe);
                chk(cya, xc);
            end
        end
        acc(2'h1, 1'b1, 1'b1, ~m);
        chk(tr, 2'h2);
        acc(2'h1, 1'b0, 1'b1, ~m);
        chk(tr, 2'h1);
        acc(2'h0, 1'b0, 1'b1, ~m);
        chk(tr, 2'h1);
        // A neighbouring encoding differs only in opc2 and must miss.
        @(posedge clk);
        enc <= 18'h3e011;
        acc(2'h2, 1'b0, 1'b1, ~m);
        @(posedge clk);
        enc <= GOOD;
        acc(2'h2, 1'b0, 1'b0, 32'h0);
        chk(cp_rdata, rdexp(m));
        end_sim;
    end
endmodule
